// ### rtl/pin_wake_defines.vh
// Purpose: Constants of the pin interrupt and wake-up block.
// Assumes: Register index times four is the AHB byte address.
// Notes: Upper address bits above the window must be zero.
`ifndef PIN_WAKE_DEFINES_VH
`define PIN_WAKE_DEFINES_VH

// Register indices (byte address = index * 4)
`define IDX_POWER_CONTROL 10'h087
`define IDX_TIMER_EXT_CTRL 10'h088
`define IDX_IRQ_FLAG_BANK 10'h095
`define IDX_PORT_WAKE_EN 10'h096
`define IDX_IRQ_ENABLE 10'h0a8
`define IDX_IRQ_ENABLE_EXT 10'h0a9

// Power control fields
`define PWR_DOZE_BIT 0
`define PWR_STOP_BIT 1
`define PWR_KEEP_MASK 8'h8c

// Timer and external interrupt control fields
`define TSEL_A_BIT 0
`define EFLAG_A_BIT 1
`define TSEL_B_BIT 2
`define EFLAG_B_BIT 3
`define TIMER_KEEP_MASK 8'hf5

// Interrupt flag bank fields
`define PFLAG_BIT 1
`define EFLAG_C_BIT 2

// Enable fields
`define EN_A_BIT 0
`define EN_B_BIT 2
`define EN_GLOBAL_BIT 7
`define EN_KEEP_MASK 8'hbf
`define PORT_EN_BIT 1
`define EN_C_BIT 2
`define EN_EXT_KEEP_MASK 8'h3f

// Reset values
`define RESET_BYTE 8'h00
`define PIN_IDLE_LEVEL 11'h7ff

`endif

// ### rtl/sync_stage.v
// Purpose: Two flip-flop synchroniser for a group of levels.
// Assumes: Each bit is an independent level.
// Notes: Reset value is a parameter so idle-high pins stay quiet.
module sync_stage #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire hclk,
    input wire hresetn,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] stable_ff;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_ff <= RESET_VAL;
            stable_ff <= RESET_VAL;
        end else begin
            meta_ff <= async_in;
            stable_ff <= meta_ff;
        end
    end

    assign sync_out = stable_ff;
endmodule // sync_stage

// ### rtl/pin_interrupt_wakeup.v
// Purpose: Pin interrupts, port change interrupt, doze and stop wake-up.
// Assumes: AHB-Lite slave, single word transfers, one clock hclk.
// Notes: Stop wake uses an asynchronous set path independent of hclk.
//
// How it works
// [RULE1] Pin c triggers on falling edge; port triggers on a change of any wake-enabled pin.
// [RULE2] Trigger select per pin a and b: 0 low level, 1 falling edge.
// [RULE3] Pin b edge flag set on falling edge whatever its enable.
// [RULE4] Pin a edge flag set on falling edge whatever its enable.
// [RULE5] Each pin edge flag clears when the core enters its service.
// [RULE6] Pin c edge flag set on falling edge even when disabled.
// [RULE7] Writing fbh to the flag bank clears only the pin c flag.
// [RULE8] Port flag set by change on a wake-enabled pin, not gated otherwise.
// [RULE9] Writing fdh to the flag bank clears only the port flag.
// [RULE10] Flag bank bits: writing 0 clears, writing 1 leaves unchanged.
// [RULE11] Doze ends only for interrupts enabled individually and globally.
// [RULE12] On doze wake the request is presented at once.
// [RULE13] Writing 1 to power control bit 1 enters stop.
// [RULE14] Writing 1 to power control bit 0 enters doze.
// [RULE15] A pin's own enable alone arms it to wake from stop.
// [RULE16] Each port wake enable bit arms its pin to wake from stop.
// [RULE17] After stop wake the next instruction runs before any service.
// [RULE18] After stop wake service needs global enable, plus port enable.
// [RULE19] Pin interrupt after stop only if its level is really sampled.
// [RULE20] Enabled pins wake from stop regardless of global enable.
// [RULE21] Port interrupt enable gates only the port request, not wake.
// [RULE22] Port change compares synchronised value with previous value.
// [RULE23] Pins synchronised twice; stop wake path is asynchronous.
`include "pin_wake_defines.vh"

module pin_interrupt_wakeup (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire ext_irq_pin_a,
    input wire ext_irq_pin_b,
    input wire ext_irq_pin_c,
    input wire [7:0] port_pins,
    input wire irq_ack_a,
    input wire irq_ack_b,
    input wire irq_ack_c,
    input wire irq_ack_port,
    input wire instr_retire,
    input wire other_irq_pending,
    output reg irq_req_a,
    output reg irq_req_b,
    output reg irq_req_c,
    output reg irq_req_port,
    output reg idle_mode,
    output reg stop_mode,
    output reg clock_restart,
    output reg post_wake_hold
);
    // Bus address phase capture
    reg rd_pend_ff;
    reg wr_pend_ff;
    reg addr_ok_ff;
    reg [9:0] addr_idx_ff;
    // Register state
    reg [7:0] pwr_keep_ff;
    reg [7:0] timer_keep_ff;
    reg edge_flag_a_ff;
    reg edge_flag_b_ff;
    reg edge_flag_c_ff;
    reg port_change_flag_ff;
    reg [7:0] port_pin_wake_enables_ff;
    reg [7:0] irq_enable_ff;
    reg [7:0] irq_enable_ext_ff;
    reg [10:0] pins_prev_ff;
    reg port_wake_ff;
    reg [31:0] rdata;
    reg nxt_flag_a;
    reg nxt_flag_b;
    reg nxt_flag_c;
    reg nxt_port_flag;

    wire [10:0] pins_sync;
    wire [1:0] wake_sync;
    wire accept;
    wire wr_now;
    wire sel_pwr;
    wire sel_tmr;
    wire sel_flg;
    wire flag_bank_wr;
    wire trigger_sel_a;
    wire trigger_sel_b;
    wire ext_irq_enable_a;
    wire ext_irq_enable_b;
    wire ext_irq_enable_c;
    wire global_irq_enable;
    wire port_change_irq_enable;
    wire [2:0] falls;
    wire [7:0] port_diff;
    wire ext_wake_async;
    wire port_wake_async;
    wire wake_async;
    wire stop_exit;
    wire pend_a;
    wire pend_b;
    wire any_enabled;
    wire doze_wake;
    wire req_gate;

    assign trigger_sel_a = timer_keep_ff[`TSEL_A_BIT];
    assign trigger_sel_b = timer_keep_ff[`TSEL_B_BIT];
    assign ext_irq_enable_a = irq_enable_ff[`EN_A_BIT];
    assign ext_irq_enable_b = irq_enable_ff[`EN_B_BIT];
    assign global_irq_enable = irq_enable_ff[`EN_GLOBAL_BIT];
    assign ext_irq_enable_c = irq_enable_ext_ff[`EN_C_BIT];
    assign port_change_irq_enable = irq_enable_ext_ff[`PORT_EN_BIT];

    // Pin synchronisation
    sync_stage #(
        .WIDTH(11),
        .RESET_VAL(`PIN_IDLE_LEVEL)
    ) u_pin_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({port_pins, ext_irq_pin_c, ext_irq_pin_b, ext_irq_pin_a}),
        .sync_out(pins_sync)
    ); // [RULE23]

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_prev_ff <= `PIN_IDLE_LEVEL;
        end else begin
            pins_prev_ff <= pins_sync;
        end
    end

    assign falls = pins_prev_ff[2:0] & ~pins_sync[2:0]; // [RULE1]
    assign port_diff = (pins_prev_ff[10:3] ^ pins_sync[10:3]) &
        port_pin_wake_enables_ff; // [RULE22]

    // Asynchronous stop wake sources
    assign ext_wake_async = stop_mode &
        ((ext_irq_enable_a & ~ext_irq_pin_a) |
         (ext_irq_enable_b & ~ext_irq_pin_b) |
         (ext_irq_enable_c & ~ext_irq_pin_c)); // [RULE15] [RULE20]
    assign port_wake_async = stop_mode &
        (|((port_pins ^ pins_prev_ff[10:3]) &
           port_pin_wake_enables_ff)); // [RULE16] [RULE21]
    assign wake_async = ext_wake_async | port_wake_async;

    always @(posedge hclk or negedge hresetn or posedge wake_async) begin
        if (!hresetn) begin
            clock_restart <= 1'b0;
        end else if (wake_async) begin
            clock_restart <= 1'b1; // [RULE23]
        end else if (!stop_mode) begin
            clock_restart <= 1'b0;
        end
    end

    always @(posedge hclk or negedge hresetn or posedge port_wake_async) begin
        if (!hresetn) begin
            port_wake_ff <= 1'b0;
        end else if (port_wake_async) begin
            port_wake_ff <= 1'b1;
        end else if (!stop_mode) begin
            port_wake_ff <= 1'b0;
        end
    end

    sync_stage #(
        .WIDTH(2),
        .RESET_VAL(2'b00)
    ) u_wake_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({port_wake_ff, clock_restart}),
        .sync_out(wake_sync)
    );

    assign stop_exit = stop_mode & wake_sync[0];

    // AHB-Lite address phase
    assign accept = hsel & htrans[1] & hready;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_ff <= 1'b0;
            wr_pend_ff <= 1'b0;
            addr_ok_ff <= 1'b0;
            addr_idx_ff <= 10'h000;
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (accept) begin
                rd_pend_ff <= ~hwrite;
                wr_pend_ff <= hwrite;
                addr_ok_ff <= (haddr[31:12] == 20'h00000);
                addr_idx_ff <= haddr[11:2];
                hreadyout <= hwrite;
            end else begin
                rd_pend_ff <= 1'b0;
                if (hready) begin
                    wr_pend_ff <= 1'b0;
                end
                hreadyout <= 1'b1;
            end
            if (rd_pend_ff) begin
                hrdata <= rdata;
            end
        end
    end

    assign wr_now = wr_pend_ff & addr_ok_ff;
    assign sel_pwr = (addr_idx_ff == `IDX_POWER_CONTROL);
    assign sel_tmr = (addr_idx_ff == `IDX_TIMER_EXT_CTRL);
    assign sel_flg = (addr_idx_ff == `IDX_IRQ_FLAG_BANK);
    assign flag_bank_wr = wr_now & sel_flg;

    // Read multiplexer
    always @* begin
        rdata = 32'h00000000;
        if (addr_ok_ff) begin
            case (addr_idx_ff)
                `IDX_POWER_CONTROL: begin
                    rdata[7:0] = pwr_keep_ff;
                    rdata[`PWR_STOP_BIT] = stop_mode;
                    rdata[`PWR_DOZE_BIT] = idle_mode;
                end
                `IDX_TIMER_EXT_CTRL: begin
                    rdata[7:0] = timer_keep_ff;
                    rdata[`EFLAG_A_BIT] = edge_flag_a_ff;
                    rdata[`EFLAG_B_BIT] = edge_flag_b_ff;
                end
                `IDX_IRQ_FLAG_BANK: begin
                    rdata[`EFLAG_C_BIT] = edge_flag_c_ff;
                    rdata[`PFLAG_BIT] = port_change_flag_ff;
                end
                `IDX_PORT_WAKE_EN: begin
                    rdata[7:0] = port_pin_wake_enables_ff;
                end
                `IDX_IRQ_ENABLE: begin
                    rdata[7:0] = irq_enable_ff;
                end
                `IDX_IRQ_ENABLE_EXT: begin
                    rdata[7:0] = irq_enable_ext_ff;
                end
                default: begin
                    rdata = 32'h00000000;
                end
            endcase
        end
    end

    // Flag next values; hardware set wins over any clear
    always @* begin
        nxt_flag_a = edge_flag_a_ff & ~irq_ack_a; // [RULE5]
        if (wr_now && sel_tmr) begin
            nxt_flag_a = hwdata[`EFLAG_A_BIT];
        end
        nxt_flag_a = nxt_flag_a | falls[0]; // [RULE4]
        nxt_flag_b = edge_flag_b_ff & ~irq_ack_b; // [RULE5]
        if (wr_now && sel_tmr) begin
            nxt_flag_b = hwdata[`EFLAG_B_BIT];
        end
        nxt_flag_b = nxt_flag_b | falls[1]; // [RULE3]
        nxt_flag_c = edge_flag_c_ff & ~irq_ack_c; // [RULE5]
        if (flag_bank_wr) begin
            nxt_flag_c = nxt_flag_c & hwdata[`EFLAG_C_BIT]; // [RULE7] [RULE10]
        end
        nxt_flag_c = nxt_flag_c | falls[2]; // [RULE6]
        nxt_port_flag = port_change_flag_ff & ~irq_ack_port;
        if (flag_bank_wr) begin
            nxt_port_flag = nxt_port_flag & hwdata[`PFLAG_BIT]; // [RULE9] [RULE10]
        end
        nxt_port_flag = nxt_port_flag | (|port_diff) |
            (stop_exit & wake_sync[1]); // [RULE8]
    end

    // Register writes and flags
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_keep_ff <= `RESET_BYTE;
            timer_keep_ff <= `RESET_BYTE;
            port_pin_wake_enables_ff <= `RESET_BYTE;
            irq_enable_ff <= `RESET_BYTE;
            irq_enable_ext_ff <= `RESET_BYTE;
            edge_flag_a_ff <= 1'b0;
            edge_flag_b_ff <= 1'b0;
            edge_flag_c_ff <= 1'b0;
            port_change_flag_ff <= 1'b0;
        end else begin
            edge_flag_a_ff <= nxt_flag_a;
            edge_flag_b_ff <= nxt_flag_b;
            edge_flag_c_ff <= nxt_flag_c;
            port_change_flag_ff <= nxt_port_flag;
            if (wr_now) begin
                case (addr_idx_ff)
                    `IDX_POWER_CONTROL: begin
                        pwr_keep_ff <= hwdata[7:0] & `PWR_KEEP_MASK;
                    end
                    `IDX_TIMER_EXT_CTRL: begin
                        timer_keep_ff <= hwdata[7:0] & `TIMER_KEEP_MASK; // [RULE2]
                    end
                    `IDX_PORT_WAKE_EN: begin
                        port_pin_wake_enables_ff <= hwdata[7:0];
                    end
                    `IDX_IRQ_ENABLE: begin
                        irq_enable_ff <= hwdata[7:0] & `EN_KEEP_MASK;
                    end
                    `IDX_IRQ_ENABLE_EXT: begin
                        irq_enable_ext_ff <= hwdata[7:0] & `EN_EXT_KEEP_MASK;
                    end
                    default: begin
                        pwr_keep_ff <= pwr_keep_ff;
                    end
                endcase
            end
        end
    end

    // Pending conditions per pin
    assign pend_a = trigger_sel_a ? edge_flag_a_ff : ~pins_sync[0]; // [RULE2]
    assign pend_b = trigger_sel_b ? edge_flag_b_ff : ~pins_sync[1]; // [RULE2]
    assign any_enabled = (ext_irq_enable_a & pend_a) |
        (ext_irq_enable_b & pend_b) |
        (ext_irq_enable_c & edge_flag_c_ff) |
        (port_change_irq_enable & port_change_flag_ff) |
        other_irq_pending;
    assign doze_wake = idle_mode & global_irq_enable & any_enabled; // [RULE11]
    assign req_gate = global_irq_enable & ~stop_mode & ~post_wake_hold;

    // Power modes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_mode <= 1'b0;
            stop_mode <= 1'b0;
            post_wake_hold <= 1'b0;
        end else begin
            if (doze_wake || stop_exit) begin
                idle_mode <= 1'b0;
            end else if (wr_now && sel_pwr) begin
                idle_mode <= hwdata[`PWR_DOZE_BIT]; // [RULE14]
            end
            if (stop_exit) begin
                stop_mode <= 1'b0;
            end else if (wr_now && sel_pwr) begin
                stop_mode <= hwdata[`PWR_STOP_BIT]; // [RULE13]
            end
            if (stop_exit) begin
                post_wake_hold <= 1'b1; // [RULE17]
            end else if (instr_retire) begin
                post_wake_hold <= 1'b0;
            end
        end
    end

    // Requests to the core, presented in the cycle doze ends
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_req_a <= 1'b0;
            irq_req_b <= 1'b0;
            irq_req_c <= 1'b0;
            irq_req_port <= 1'b0;
        end else begin
            irq_req_a <= req_gate & ext_irq_enable_a & pend_a; // [RULE12] [RULE19]
            irq_req_b <= req_gate & ext_irq_enable_b & pend_b; // [RULE19]
            irq_req_c <= req_gate & ext_irq_enable_c & edge_flag_c_ff;
            irq_req_port <= req_gate & port_change_irq_enable &
                port_change_flag_ff; // [RULE18] [RULE21]
        end
    end
endmodule // pin_interrupt_wakeup

// ### tb/core_model.sv
// Purpose: Core sequencer model that serves requests and retires code.
// Assumes: One request is served at a time while serve is high.
// Notes: After a stop wake one instruction retires before any service.
module core_model (
    input wire hclk,
    input wire hresetn,
    input wire serve,
    input wire [3:0] req,
    input wire hold,
    output logic [3:0] ack,
    output logic retire
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] gap_ff;
    logic hold_ff;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack <= 4'h0;
            retire <= 1'b0;
            gap_ff <= 2'h0;
            hold_ff <= 1'b0;
        end else begin
            hold_ff <= hold;
            // Next instruction completes first
            retire <= hold && hold_ff && !retire;
            ack <= 4'h0;
            if (gap_ff != 2'h0) begin
                gap_ff <= gap_ff - 2'h1;
            end else if (serve && req != 4'h0) begin
                // Service entry of the lowest pending source
                ack <= req & (~req + 4'h1);
                gap_ff <= 2'h3;
            end
        end
    end
endmodule // core_model

// ### tb/wake_checker_assertions.sv
// Purpose: Concurrent checks on the pin interrupt and wake-up ports.
// Assumes: One clock hclk, reset hresetn active low.
// Notes: Power control sits at byte address 21ch.
module wake_checker (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire irq_ack_c,
    input wire instr_retire,
    input wire other_irq_pending,
    input wire irq_req_a,
    input wire irq_req_b,
    input wire irq_req_c,
    input wire irq_req_port,
    input wire idle_mode,
    input wire stop_mode,
    input wire clock_restart,
    input wire post_wake_hold
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pw_ff;
    wire any_req = irq_req_a | irq_req_b | irq_req_c | irq_req_port;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pw_ff <= 1'b0;
        end else if (hready) begin
            pw_ff <= hsel && htrans[1] && hwrite && haddr == 32'h21c;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    stop_entry_a: assert property (
        pw_ff && hready && hwdata[1] |-> ##[1:2] stop_mode)
        else $error("stop mode not entered");
    doze_entry_a: assert property (
        pw_ff && hready && hwdata[0] |-> ##[1:2] idle_mode)
        else $error("doze mode not entered");
    doze_exit_a: assert property (
        $fell(idle_mode) |-> any_req || other_irq_pending)
        else $error("doze left without a request");
    stop_exit_a: assert property (
        $fell(stop_mode) |-> post_wake_hold)
        else $error("stop left without hold");
    hold_mask_a: assert property (
        post_wake_hold |-> !any_req)
        else $error("request during post wake hold");
    hold_end_a: assert property (
        post_wake_hold && instr_retire |=> !post_wake_hold)
        else $error("hold kept after retire");
    wake_start_a: assert property (
        stop_mode && clock_restart |-> ##[1:4] !stop_mode)
        else $error("stop not left after wake");
    ack_clear_a: assert property (
        irq_ack_c |-> ##2 !irq_req_c)
        else $error("request kept after service entry");
    read_wait_a: assert property (
        hsel && htrans[1] && hready && !hwrite |=>
        !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
endmodule // wake_checker

bind pin_interrupt_wakeup wake_checker wake_checker_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .irq_ack_c, .instr_retire, .other_irq_pending,
    .irq_req_a, .irq_req_b, .irq_req_c, .irq_req_port, .idle_mode,
    .stop_mode, .clock_restart, .post_wake_hold
);

// ### tb/pin_interrupt_wakeup_bench.sv
// Purpose: Self-checking bench for the pin interrupt and wake-up block.
// Assumes: One AHB-Lite master; core model serves on demand.
// Notes: hclk keeps running in stop; narrow pulses fall between edges.
module pin_interrupt_wakeup_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] PWR = 32'h21c;
    localparam logic [31:0] TMR = 32'h220;
    localparam logic [31:0] FLG = 32'h254;
    localparam logic [31:0] WKE = 32'h258;
    localparam logic [31:0] IEN = 32'h2a0;
    localparam logic [31:0] IEX = 32'h2a4;
    logic hclk, hresetn, hwrite, serve;
    logic ext_irq_pin_a, ext_irq_pin_b, ext_irq_pin_c;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata;
    logic [7:0] port_pins;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq_ack_a, irq_ack_b, irq_ack_c, irq_ack_port;
    wire irq_req_a, irq_req_b, irq_req_c, irq_req_port, instr_retire;
    wire idle_mode, stop_mode, clock_restart, post_wake_hold;
    integer n_mismatch = 0;
    integer checks = 0;
    integer cyc = 0;

    pin_interrupt_wakeup pin_interrupt_wakeup_i (
        .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .ext_irq_pin_a, .ext_irq_pin_b, .ext_irq_pin_c,
        .port_pins, .irq_ack_a, .irq_ack_b, .irq_ack_c, .irq_ack_port,
        .instr_retire, .other_irq_pending(1'b0), .irq_req_a, .irq_req_b,
        .irq_req_c, .irq_req_port, .idle_mode, .stop_mode,
        .clock_restart, .post_wake_hold
    );
    core_model core_model_i (
        .hclk, .hresetn, .serve,
        .req({irq_req_port, irq_req_c, irq_req_b, irq_req_a}),
        .ack({irq_ack_port, irq_ack_c, irq_ack_b, irq_ack_a}),
        .hold(post_wake_hold), .retire(instr_retire)
    );

    task automatic conclude;
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks = checks + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic chb(input string nm, input logic e, g);
        checks = checks + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value %s: expected %b, seen %b", nm, e, g);
        end
    endtask
    task automatic tick(input integer n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic wr(input logic [31:0] a, d);
        haddr <= a;
        hwrite <= 1'b1;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [31:0] a, e);
        haddr <= a;
        hwrite <= 1'b0;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        chk("read data", e, hrdata);
    endtask

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch = n_mismatch + 1;
            conclude;
        end
    end

    initial begin
        hresetn = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        serve = 1'b0;
        ext_irq_pin_a = 1'b1;
        ext_irq_pin_b = 1'b1;
        ext_irq_pin_c = 1'b1;
        port_pins = 8'hff;
        tick(6);
        hresetn <= 1'b1;
        tick(1);
        for (int i = 0; i < 4; i++) begin
            rd(PWR + 32'h4 * i, 32'h0);
        end
        rd(32'h300, 32'h0);
        wr(WKE, 32'h01);
        port_pins[1] <= 1'b0;
        tick(6);
        rd(FLG, 32'h00);
        port_pins[0] <= 1'b0;
        ext_irq_pin_c <= 1'b0;
        tick(6);
        rd(FLG, 32'h06);
        wr(FLG, 32'hfb);
        rd(FLG, 32'h02);
        ext_irq_pin_c <= 1'b1;
        tick(4);
        ext_irq_pin_c <= 1'b0;
        tick(6);
        wr(FLG, 32'hfd);
        rd(FLG, 32'h04);
        wr(FLG, 32'hff);
        rd(FLG, 32'h04);
        port_pins[0] <= 1'b1;
        ext_irq_pin_c <= 1'b1;
        tick(6);
        rd(FLG, 32'h06);
        wr(FLG, 32'h00);
        rd(FLG, 32'h00);
        wr(TMR, 32'h05);
        ext_irq_pin_a <= 1'b0;
        ext_irq_pin_b <= 1'b0;
        tick(6);
        rd(TMR, 32'h0f);
        chb("request a", 1'b0, irq_req_a);
        serve <= 1'b1;
        wr(IEN, 32'h81);
        tick(8);
        chb("request a", 1'b0, irq_req_a);
        rd(TMR, 32'h0d);
        ext_irq_pin_a <= 1'b1;
        serve <= 1'b0;
        wr(TMR, 32'h01);
        wr(IEN, 32'h85);
        tick(4);
        chb("request b", 1'b1, irq_req_b);
        ext_irq_pin_b <= 1'b1;
        tick(6);
        chb("request b", 1'b0, irq_req_b);
        wr(IEN, 32'h00);
        wr(IEX, 32'h04);
        wr(PWR, 32'h01);
        tick(2);
        chb("doze", 1'b1, idle_mode);
        ext_irq_pin_c <= 1'b0;
        tick(6);
        chb("doze", 1'b1, idle_mode);
        wr(IEN, 32'h80);
        tick(3);
        chb("doze", 1'b0, idle_mode);
        chb("request c", 1'b1, irq_req_c);
        serve <= 1'b1;
        tick(6);
        chb("request c", 1'b0, irq_req_c);
        ext_irq_pin_c <= 1'b1;
        wr(IEN, 32'h01);
        wr(PWR, 32'h02);
        tick(2);
        chb("stop", 1'b1, stop_mode);
        #10 ext_irq_pin_a <= 1'b0;
        #10 ext_irq_pin_a <= 1'b1;
        tick(6);
        chb("stop", 1'b0, stop_mode);
        chb("request a", 1'b0, irq_req_a);
        rd(TMR, 32'h01);
        wr(IEN, 32'h80);
        wr(IEX, 32'h00);
        wr(WKE, 32'h08);
        wr(PWR, 32'h02);
        tick(2);
        port_pins[3] <= 1'b0;
        tick(6);
        chb("stop", 1'b0, stop_mode);
        chb("request port", 1'b0, irq_req_port);
        rd(FLG, 32'h02);
        conclude;
    end
endmodule // pin_interrupt_wakeup_bench
